// >>> asr_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "asr_cfg.svh"
module asr_readout
    import asr_pkg::*;
#(
    parameter int FIFO_DEPTH = `ASR_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire asr_pins_type hostPins,
    input wire logic [7:0] outputProtocolControl,
    input wire logic [1:0] inputProtocolControl,
    input wire logic [`ASR_WORD_BITS-1:0] sampleData,
    input wire logic sampleValid,
    output logic sampleReady,
    output logic [3:0] serialOut,
    output logic readyOrOutputClock,
    output logic commandValid,
    output logic [`ASR_WORD_BITS-1:0] commandWord,
    output logic sampleTaken
);

    function automatic logic [1:0] laneShift(input logic [1:0] w);
        laneShift = (w == `ASR_WIDTH_QUAD) ? 2'h2 : ((w == `ASR_WIDTH_DUAL) ? 2'h1 : 2'h0);
    endfunction : laneShift

    // Lane k carries the bit k places below the MSB.
    function automatic logic [3:0] laneBits(input logic [19:0] r, input logic [1:0] s);
        logic [3:0] b;
        b = 4'h0;
        for (int k = 0; k < 4; k++) begin
            if (k < (1 << s)) begin
                b[k] = r[19-k];
            end
        end
        return b;
    endfunction : laneBits

    function automatic logic [19:0] shiftIn(input logic [19:0] r, input logic [1:0] s,
                                           input logic fill);
        case (s)
            2'h0: shiftIn = {r[18:0], fill};
            2'h1: shiftIn = {r[17:0], 2'h0};
            default: shiftIn = {r[15:0], 4'h0};
        endcase
    endfunction : shiftIn

    function automatic logic [5:0] clocksFor(input asr_ctrl_type c);
        logic [2:0] sh;
        sh = {1'b0, laneShift(c.width)} + {2'h0, c.ddr};
        return `ASR_SYNC_BITS >> sh;
    endfunction : clocksFor

    asr_pins_type pinMeta;
    asr_pins_type pinSync;
    asr_pins_type pinPrev;
    asr_ctrl_type ctrlNow;
    asr_ctrl_type frameCtrl;
    asr_state_type state;

    logic [`ASR_WORD_BITS-1:0] unifiedShiftReg;
    logic [`ASR_WORD_BITS-1:0] inputDataReg;
    logic [`ASR_WORD_BITS-1:0] outputDataReg;
    logic [`ASR_WORD_BITS-1:0] fifoData;
    logic fifoValid;
    logic csFall;
    logic csRise;
    logic sclkRise;
    logic sclkFall;
    logic convRise;
    logic captureEdge;
    logic launchEdge;
    logic daisy;
    logic extSource;
    logic [1:0] lanes;
    logic [1:0] divCount;
    logic [1:0] halfLimit;
    logic divTick;
    logic [5:0] edgesLeft;
    logic syncLaunch;
    logic legacyLaunch;
    logic intToggle;

    // Pins pass two flops; edge detects compare the second stage with a third, delayed stage.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinMeta <= asr_pins_type'(`ASR_PINS_IDLE);
            pinSync <= asr_pins_type'(`ASR_PINS_IDLE);
            pinPrev <= asr_pins_type'(`ASR_PINS_IDLE);
        end else if (ce) begin
            pinMeta <= hostPins;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    assign csFall = pinPrev.csN && !pinSync.csN;
    assign csRise = !pinPrev.csN && pinSync.csN;
    assign sclkRise = !pinPrev.sclk && pinSync.sclk;
    assign sclkFall = pinPrev.sclk && !pinSync.sclk;
    assign convRise = !pinPrev.convStart && pinSync.convStart;

    // Modes 00 and 11 capture on the rising edge, 01 and 10 on the falling edge.
    assign captureEdge = (inputProtocolControl[1] == inputProtocolControl[0]) ?
                         sclkRise : sclkFall;
    assign launchEdge = (inputProtocolControl[1] == inputProtocolControl[0]) ?
                        sclkFall : sclkRise;

    assign ctrlNow = asr_ctrl_type'(outputProtocolControl);
    assign daisy = (frameCtrl == asr_ctrl_type'(`ASR_CTRL_DAISY));
    assign extSource = (frameCtrl.clkSel == `ASR_CLK_EXT);
    assign lanes = laneShift(frameCtrl.width);

    // Control is latched per frame so a mid-frame change cannot tear a word.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            frameCtrl <= asr_ctrl_type'(`ASR_CTRL_DAISY);
        end else if (ce && csFall) begin
            frameCtrl <= ctrlNow;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ASR_IDLE;
        end else if (ce) begin
            unique case (state)
                ASR_IDLE: begin
                    if (csFall) begin
                        state <= (ctrlNow.mode == `ASR_MODE_SYNC) ? ASR_SYNC : ASR_LEGACY;
                    end
                end
                ASR_LEGACY, ASR_SYNC: begin
                    if (csRise) begin
                        state <= ASR_IDLE;
                    end
                end
            endcase
        end
    end

    // Internal clock runs at clk rate per half period when undivided.
    always_comb begin
        unique case (frameCtrl.clkSel)
            `ASR_CLK_INT: halfLimit = `ASR_HALF_INT;
            `ASR_CLK_IB2: halfLimit = `ASR_HALF_IB2;
            `ASR_CLK_IB4: halfLimit = `ASR_HALF_IB4;
            `ASR_CLK_EXT: halfLimit = `ASR_HALF_INT;
        endcase
    end

    assign divTick = (divCount == halfLimit);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            divCount <= 2'h0;
        end else if (ce) begin
            if (csFall || divTick) begin
                divCount <= 2'h0;
            end else begin
                divCount <= divCount + 2'h1;
            end
        end
    end

    assign intToggle = (state == ASR_SYNC) && !extSource && divTick && (edgesLeft != 6'h00);

    // Rising output clock launches in single rate; every edge launches in double rate.
    always_comb begin
        if (state != ASR_SYNC || edgesLeft == 6'h00) begin
            syncLaunch = 1'b0;
        end else if (extSource) begin
            syncLaunch = sclkRise || (frameCtrl.ddr && sclkFall);
        end else begin
            syncLaunch = intToggle && (!readyOrOutputClock || frameCtrl.ddr);
        end
    end

    assign legacyLaunch = (state == ASR_LEGACY) && launchEdge;

    // Echo mode counts launches; internal mode counts output clock toggles.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            edgesLeft <= 6'h00;
        end else if (ce) begin
            if (csFall) begin
                edgesLeft <= (ctrlNow.clkSel == `ASR_CLK_EXT) ?
                             (`ASR_SYNC_BITS >> laneShift(ctrlNow.width)) :
                             (clocksFor(ctrlNow) << 1);
            end else if (extSource ? syncLaunch : intToggle) begin
                edgesLeft <= edgesLeft - 6'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            readyOrOutputClock <= 1'b0;
        end else if (ce) begin
            if (state != ASR_SYNC) begin
                readyOrOutputClock <= 1'b0;
            end else if (extSource) begin
                readyOrOutputClock <= pinSync.sclk;
            end else if (intToggle) begin
                readyOrOutputClock <= !readyOrOutputClock;
            end
        end
    end

    // Out of daisy settings the word is followed by zeros.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            unifiedShiftReg <= `ASR_WORD_RESET;
        end else if (ce) begin
            if (csFall) begin
                unifiedShiftReg <= outputDataReg;
            end else if (state == ASR_LEGACY && captureEdge) begin
                unifiedShiftReg <= shiftIn(unifiedShiftReg, lanes,
                                           daisy && pinSync.sdi);
            end else if (syncLaunch) begin
                unifiedShiftReg <= shiftIn(unifiedShiftReg, lanes, 1'b0);
            end
        end
    end

    // Writes follow the input protocol whatever the read protocol.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            inputDataReg <= `ASR_WORD_RESET;
        end else if (ce) begin
            if (csFall) begin
                inputDataReg <= `ASR_WORD_RESET;
            end else if (state != ASR_IDLE && captureEdge) begin
                inputDataReg <= {inputDataReg[`ASR_WORD_BITS-2:0], pinSync.sdi};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            serialOut <= 4'h0;
        end else if (ce) begin
            if (csFall) begin
                serialOut <= (ctrlNow.mode == `ASR_MODE_SYNC) ? 4'h0 :
                             laneBits(outputDataReg, laneShift(ctrlNow.width));
            end else if (csRise) begin
                serialOut <= 4'h0;
            end else if (legacyLaunch || syncLaunch) begin
                serialOut <= laneBits(unifiedShiftReg, lanes);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            commandValid <= 1'b0;
            commandWord <= `ASR_WORD_RESET;
        end else if (ce) begin
            commandValid <= csRise && (state != ASR_IDLE);
            if (csRise && state != ASR_IDLE) begin
                commandWord <= daisy ? unifiedShiftReg : inputDataReg;
            end
        end
    end

    // An empty buffer leaves the previous sample in place.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            outputDataReg <= `ASR_WORD_RESET;
            sampleTaken <= 1'b0;
        end else if (ce) begin
            sampleTaken <= convRise && fifoValid;
            if (convRise && fifoValid) begin
                outputDataReg <= fifoData;
            end
        end
    end

    asr_fifo #(
        .WIDTH(`ASR_WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData(sampleData),
        .outValid(fifoValid),
        .outReady(convRise),
        .outData(fifoData)
    );

    logic prevClock;
    logic [5:0] riseCount;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prevClock <= 1'b0;
            riseCount <= 6'h00;
        end else if (ce) begin
            prevClock <= readyOrOutputClock;
            if (csFall) begin
                riseCount <= 6'h00;
            end else if (readyOrOutputClock && !prevClock) begin
                riseCount <= riseCount + 6'h01;
            end
        end
    end

    a_dual_lanes: assert property (@(posedge clk) disable iff (!nrst)
        syncLaunch && ce && lanes == 2'h1 |=>
        serialOut == {2'h0, $past(unifiedShiftReg[18]), $past(unifiedShiftReg[19])})
        else $error("dual launch lanes wrong");

    a_quad_lanes: assert property (@(posedge clk) disable iff (!nrst)
        syncLaunch && ce && lanes == 2'h2 |=>
        serialOut == {$past(unifiedShiftReg[16]), $past(unifiedShiftReg[17]),
                      $past(unifiedShiftReg[18]), $past(unifiedShiftReg[19])})
        else $error("quad launch lanes wrong");

    a_sdr_rising: assert property (@(posedge clk) disable iff (!nrst)
        syncLaunch && ce && !extSource && !frameCtrl.ddr |=>
        readyOrOutputClock && !$past(readyOrOutputClock))
        else $error("single rate launch not on rising clock");

    a_ddr_toggle: assert property (@(posedge clk) disable iff (!nrst)
        intToggle && ce && frameCtrl.ddr |-> syncLaunch ##1
        readyOrOutputClock != $past(readyOrOutputClock))
        else $error("double rate clock did not toggle");

    a_clock_count: assert property (@(posedge clk) disable iff (!nrst)
        state == ASR_SYNC && !extSource && edgesLeft == 6'h00 && prevClock == 1'b0 &&
        !readyOrOutputClock |-> riseCount == clocksFor(frameCtrl))
        else $error("output clock count wrong");

    a_echo_clock: assert property (@(posedge clk) disable iff (!nrst)
        state == ASR_SYNC && extSource && ce && !csRise |=>
        readyOrOutputClock == $past(pinSync.sclk))
        else $error("output clock does not echo serial clock");

    a_daisy_shift: assert property (@(posedge clk) disable iff (!nrst)
        state == ASR_LEGACY && daisy && captureEdge && ce |=>
        unifiedShiftReg == {$past(unifiedShiftReg[18:0]), $past(pinSync.sdi)})
        else $error("daisy capture shift wrong");

    a_daisy_msb: assert property (@(posedge clk) disable iff (!nrst)
        state == ASR_LEGACY && daisy && launchEdge && ce |=>
        serialOut[0] == $past(unifiedShiftReg[19]))
        else $error("line zero does not carry the MSB");

    a_cmd_decode: assert property (@(posedge clk) disable iff (!nrst)
        csRise && state != ASR_IDLE && daisy && ce |=>
        commandValid && commandWord == $past(unifiedShiftReg) ##1 !commandValid || !ce)
        else $error("command not decoded at select rise");

    a_hold_idle: assert property (@(posedge clk) disable iff (!nrst)
        state == ASR_IDLE && !csFall |=> $stable(unifiedShiftReg))
        else $error("register moved while select high");

    a_conv_sample: assert property (@(posedge clk) disable iff (!nrst)
        convRise && fifoValid && ce |=> outputDataReg == $past(fifoData) && sampleTaken)
        else $error("sample not taken on start rise");

endmodule : asr_readout
`default_nettype wire

// >>> asr_cfg.svh
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

// Word, frame and buffer sizes.
`define ASR_WORD_BITS 20
`define ASR_SYNC_BITS 6'h10
`define ASR_FIFO_DEPTH 16

// Output control byte field positions.
`define ASR_CLKSEL_MSB 7
`define ASR_CLKSEL_LSB 6
`define ASR_RATE_BIT 4
`define ASR_WIDTH_MSB 3
`define ASR_WIDTH_LSB 2
`define ASR_MODE_MSB 1
`define ASR_MODE_LSB 0

// Field encodings.
`define ASR_MODE_SYNC 2'h3
`define ASR_CTRL_DAISY 8'h00
`define ASR_WIDTH_DUAL 2'h2
`define ASR_WIDTH_QUAD 2'h3
`define ASR_CLK_EXT 2'h0
`define ASR_CLK_INT 2'h1
`define ASR_CLK_IB2 2'h2
`define ASR_CLK_IB4 2'h3

// Internal clock half periods, in clk cycles, minus one.
`define ASR_HALF_INT 2'h0
`define ASR_HALF_IB2 2'h1
`define ASR_HALF_IB4 2'h3

// Reset values.
`define ASR_PINS_IDLE 4'h8
`define ASR_WORD_RESET 20'h0_0000

`endif

// >>> asr_pkg.sv
`default_nettype none
package asr_pkg;

    // Field order matches the output control byte, bit 7 first.
    typedef struct packed {
        logic [1:0] clkSel;
        logic reserved;
        logic ddr;
        logic [1:0] width;
        logic [1:0] mode;
    } asr_ctrl_type;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic sdi;
        logic convStart;
    } asr_pins_type;

    typedef enum logic [1:0] {
        ASR_IDLE,
        ASR_LEGACY,
        ASR_SYNC
    } asr_state_type;

endpackage : asr_pkg
`default_nettype wire

// >>> asr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module asr_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign push = inValid && inReady && ce;
    assign pop = outValid && outReady && ce;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule : asr_fifo
`default_nettype wire

// >>> asr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host_model
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] serialOut,
    input wire logic outClk,
    output var asr_pins_type pins
);
    logic echo = 1'b0;
    logic ddr = 1'b0;
    logic lastClk = 1'b0;
    logic late = 1'b0;
    logic take;
    int lanes = 1;
    int nRise = 0;
    logic [31:0] cap = '0;

    initial begin
        pins = 4'h8;
    end

    // Echoed clocks trail the pins, so their data is taken one cycle after the edge.
    always @(posedge clk) begin
        take = echo ? late : outClk != lastClk;
        if (take && (ddr || outClk)) begin
            for (int k = 0; k < lanes; k++) begin
                cap = {cap[30:0], serialOut[k]};
            end
        end
        nRise <= nRise + int'(outClk && !lastClk);
        late <= echo && (outClk != lastClk);
        lastClk <= outClk;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold

    // Start is driven apart from select, which the minimal wiring also allows.
    task automatic convert();
        pins.convStart <= 1'b1;
        hold(6);
        pins.convStart <= 1'b0;
        hold(6);
    endtask : convert

    task automatic syncFrame(input logic [7:0] c);
        int n;
        int h;
        echo = c[7:6] == 2'h0;
        ddr = c[4];
        lanes = (c[3:2] == 2'h3) ? 4 : (c[3:2] == 2'h2) ? 2 : 1;
        n = 16 / lanes / (ddr ? 2 : 1);
        h = (c[7:6] == 2'h3) ? 4 : int'(c[7:6]);
        pins.csN <= 1'b0;
        hold(4);
        if (echo) begin
            repeat (n) begin
                pins.sclk <= 1'b1;
                hold(4);
                pins.sclk <= 1'b0;
                hold(4);
            end
        end else begin
            hold(2 * n * h + 4);
        end
        hold(6);
        pins.csN <= 1'b1;
        hold(6);
    endtask : syncFrame

    // Legacy frame with capture on the rising clock; only line zero is read back.
    task automatic spiFrame(input int nBits, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        pins.csN <= 1'b0;
        for (int i = nBits - 1; i >= 0; i--) begin
            pins.sdi <= tx[i];
            hold(4);
            rx = {rx[62:0], serialOut[0]};
            pins.sclk <= 1'b1;
            hold(4);
            pins.sclk <= 1'b0;
        end
        hold(4);
        pins.csN <= 1'b1;
        hold(8);
    endtask : spiFrame
endmodule : asr_host_model
`default_nettype wire

// >>> asr_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module asr_readout_tb
    import asr_pkg::*;
;
    typedef struct packed {
        logic [7:0] c;
        logic [4:0] n;
    } asr_row_type;

    asr_row_type rows [24] = '{
        '{8'h03, 5'h10}, '{8'h43, 5'h10}, '{8'h83, 5'h10}, '{8'hC3, 5'h10},
        '{8'h0B, 5'h08}, '{8'h4B, 5'h08}, '{8'h8B, 5'h08}, '{8'hCB, 5'h08},
        '{8'h0F, 5'h04}, '{8'h4F, 5'h04}, '{8'h8F, 5'h04}, '{8'hCF, 5'h04},
        '{8'h13, 5'h08}, '{8'h53, 5'h08}, '{8'h93, 5'h08}, '{8'hD3, 5'h08},
        '{8'h1B, 5'h04}, '{8'h5B, 5'h04}, '{8'h9B, 5'h04}, '{8'hDB, 5'h04},
        '{8'h1F, 5'h02}, '{8'h5F, 5'h02}, '{8'h9F, 5'h02}, '{8'hDF, 5'h02}
    };

    logic clk;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    asr_pins_type hostPins;
    logic [7:0] ctrl = 8'h00;
    logic [1:0] inCtrl = 2'h0;
    logic [19:0] sampleData = 20'h0_0000;
    logic sampleValid = 1'b0;
    logic sampleReady;
    logic [3:0] serialOut;
    logic outClk;
    logic commandValid;
    logic [19:0] commandWord;
    logic sampleTaken;
    logic [19:0] w;
    logic [63:0] rx;
    int n_errors = 0;
    int n_tests = 0;
    int nCmd = 0;
    int nTaken = 0;
    int cycles = 0;
    int t;

    asr_readout #(.FIFO_DEPTH(4)) i_asr_readout (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .hostPins(hostPins),
        .outputProtocolControl(ctrl),
        .inputProtocolControl(inCtrl),
        .sampleData(sampleData),
        .sampleValid(sampleValid),
        .sampleReady(sampleReady),
        .serialOut(serialOut),
        .readyOrOutputClock(outClk),
        .commandValid(commandValid),
        .commandWord(commandWord),
        .sampleTaken(sampleTaken)
    );

    asr_host_model i_asr_host_model (
        .clk(clk),
        .serialOut(serialOut),
        .outClk(outClk),
        .pins(hostPins)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // The whole run needs about 2600 cycles; a hang is cut off well beyond that.
    always @(posedge clk) begin
        nCmd <= nCmd + int'(commandValid === 1'b1);
        nTaken <= nTaken + int'(sampleTaken === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic push(input logic [19:0] d);
        sampleData <= d;
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        @(posedge clk);
    endtask : push

    task automatic readSync(input logic [7:0] c, input int clocks, input logic [19:0] d);
        int r0;
        r0 = i_asr_host_model.nRise;
        ctrl <= c;
        i_asr_host_model.syncFrame(c);
        `CHECK(i_asr_host_model.cap[15:0], d[19:4])
        `CHECK(i_asr_host_model.nRise - r0, clocks)
    endtask : readSync

    initial begin
        repeat (6) @(posedge clk);
        `CHECK({serialOut, outClk, commandValid, sampleTaken, sampleReady}, 8'h01)
        `CHECK(commandWord, 20'h0_0000)
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            w = 20'h9_C3A5 ^ 20'(i * 20'h0_4321);
            inCtrl <= 2'(i);
            push(w);
            i_asr_host_model.convert();
            readSync(rows[i].c, int'(rows[i].n), w);
        end
        // Fill the buffer past its depth, then drain it in order.
        for (int i = 0; i < 5; i++) begin
            push(20'h3_0A5C + 20'(i * 20'h1_1111));
        end
        `CHECK(sampleReady, 1'b0)
        t = nTaken;
        for (int i = 0; i < 4; i++) begin
            i_asr_host_model.convert();
            readSync(8'h43, 16, 20'h3_0A5C + 20'(i * 20'h1_1111));
        end
        i_asr_host_model.convert();
        `CHECK(nTaken - t, 4)
        ctrl <= 8'h00;
        inCtrl <= 2'h0;
        push(20'h5_A0F3);
        i_asr_host_model.convert();
        t = nCmd;
        i_asr_host_model.spiFrame(40, {24'h00_0000, 20'hC_1234, 20'h3_9ABC}, rx);
        `CHECK(rx[39:0], {20'h5_A0F3, 20'hC_1234})
        `CHECK(commandWord, 20'h3_9ABC)
        `CHECK(nCmd - t, 1)
        // Outside daisy settings the word is followed by zeros and commands come from sdi.
        ctrl <= 8'h08;
        i_asr_host_model.spiFrame(20, 64'h6_D2B7, rx);
        `CHECK(rx[19:0], 20'h3_3400)
        `CHECK(commandWord, 20'h6_D2B7)
        // A low enable freezes the pin stages, so a start pulse inside it is never seen.
        push(20'h1_2345);
        t = nTaken;
        ce <= 1'b0;
        i_asr_host_model.convert();
        ce <= 1'b1;
        i_asr_host_model.hold(4);
        `CHECK(nTaken - t, 0)
        // A reset in mid-run must empty the buffer and clear the command word.
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHECK({serialOut, outClk, commandValid, sampleTaken, sampleReady}, 8'h01)
        `CHECK(commandWord, 20'h0_0000)
        nrst <= 1'b1;
        i_asr_host_model.convert();
        `CHECK(nTaken - t, 0)
        conclude();
    end
endmodule : asr_readout_tb
`default_nettype wire
